// file: resmon_defs.vh
// constants for the reservation monitor
`ifndef RESMON_DEFS_VH
`define RESMON_DEFS_VH
`define RESMON_AW          64
`define RESMON_DW          64
`define RESMON_GRAN_LSB    7
`define RESMON_TAG_W       57
`define RESMON_SZ_WORD     1'b0
`define RESMON_SZ_DWORD    1'b1
`define RESMON_WORD_ALIGN  2
`define RESMON_DWORD_ALIGN 3
`define RESMON_CR_BIT      2
`define RESMON_CR_W        4
`define RESMON_CR_ZERO     4'h0
`define RESMON_ADDR_ZERO   64'h0000000000000000
`define RESMON_DATA_ZERO   64'h0000000000000000
`define RESMON_TAG_ZERO    57'h000000000000000
`define RESMON_WORD_LOW_ZERO  2'h0
`define RESMON_DWORD_LOW_ZERO 3'h0
`define RESMON_BUILD_32    0
`endif

// file: resmon_monitor.v
// reservation monitor: one granule reservation, conditional store decision
`timescale 1ns/100ps
`default_nettype none
`include "resmon_defs.vh"

// Contract
// R1: a reserve load returns the addressed data and reserves the aligned 128-byte granule holding the address.
// R2: a conditional store with no reservation held completes without writing memory.
// R3: after a conditional store bit 2 of first_condition_field is one if the write happened and zero otherwise.
// R4: at most one reservation is held and a later reserve load may move it.
// R5: a new word or doubleword reserve load drops the old reservation and records the new address.
// R6: any conditional store from this element clears the reservation whatever its address.
// R7: another element's store, block-zero or referenced/changed bit update to the granule clears the reservation.
// R8: another element's touch-for-store, block-store or flush to the granule may clear it; here it clears.
// R9: any other mechanism modifying the granule clears it; the holder's own bit update leaves it alone.
// R10: exceptions and interrupts leave the reservation untouched.
// R11: a matched pair gives an atomic word update, and doubleword only in the 64-bit build.
// R12: the core supplies naturally aligned addresses for reserve and conditional store.
// R13: the core pairs reserves and conditional stores by size and address; a lone conditional store only clears.
// R14: a reserve load never followed by a conditional store is accepted without error.
// R15: the core should place no flush between a reserve load and its conditional store.
// R16: reset clears the reservation so an early conditional store fails and reports zero.
module resmon_monitor #(
   parameter IS_64BIT = 1
) (
   input  wire                      clk_in,
   input  wire                      rst_in,
   input  wire                      rsv_ld_in,
   input  wire                      cond_st_in,
   input  wire                      op_size_in,
   input  wire [`RESMON_AW-1:0]     op_addr_in,
   input  wire [`RESMON_DW-1:0]     st_data_in,
   input  wire                      mem_rd_valid_in,
   input  wire [`RESMON_DW-1:0]     mem_rd_data_in,
   input  wire                      snoop_valid_in,
   input  wire [`RESMON_AW-1:0]     snoop_addr_in,
   input  wire                      snoop_modify_in,
   input  wire                      snoop_cache_op_in,
   input  wire                      own_rc_update_in,
   input  wire                      exception_in,
   output reg                       mem_rd_req_out,
   output reg  [`RESMON_AW-1:0]     mem_addr_out,
   output reg                       mem_wr_out,
   output reg  [`RESMON_DW-1:0]     mem_wr_data_out,
   output reg                       mem_wr_size_out,
   output reg                       ld_valid_out,
   output reg  [`RESMON_DW-1:0]     ld_data_out,
   output reg                       st_done_out,
   output reg  [`RESMON_CR_W-1:0]   first_condition_field_out,
   output reg                       rsv_valid_out,
   output reg                       align_err_out
);

   localparam ST_IDLE = 2'b01;
   localparam ST_LOAD = 2'b10;

   // control and reservation state
   reg  [1:0]                 state_r;
   reg  [1:0]                 state_nxt;
   reg  [`RESMON_TAG_W-1:0]   rsv_tag_r;
   reg  [`RESMON_TAG_W-1:0]   rsv_tag_nxt;
   reg                        rsv_valid_nxt;
   reg                        align_err_nxt;
   // memory request side
   reg                        mem_rd_req_nxt;
   reg  [`RESMON_AW-1:0]      mem_addr_nxt;
   reg                        mem_wr_nxt;
   reg  [`RESMON_DW-1:0]      mem_wr_data_nxt;
   reg                        mem_wr_size_nxt;
   // results toward the core
   reg                        ld_valid_nxt;
   reg  [`RESMON_DW-1:0]      ld_data_nxt;
   reg                        st_done_nxt;
   reg  [`RESMON_CR_W-1:0]    cr_nxt;

   wire [`RESMON_TAG_W-1:0]   op_tag;
   wire [`RESMON_TAG_W-1:0]   snoop_tag;
   wire                       word_misaligned;
   wire                       dword_misaligned;
   wire                       misaligned;
   wire                       size_ok;
   wire                       op_bad;
   wire                       idle;
   wire                       rsv_take;
   wire                       rsv_start;
   wire                       cs_take;
   wire                       ld_return;
   wire                       snoop_clears;
   wire                       snoop_hit;
   wire                       st_ok;
   wire                       cs_write;

   assign op_tag    = op_addr_in[`RESMON_AW-1:`RESMON_GRAN_LSB];
   assign snoop_tag = snoop_addr_in[`RESMON_AW-1:`RESMON_GRAN_LSB];

   // the core is trusted to align; a slip is flagged and the op dropped
   assign word_misaligned  = (op_addr_in[`RESMON_WORD_ALIGN-1:0] != `RESMON_WORD_LOW_ZERO); // see R12
   assign dword_misaligned = (op_addr_in[`RESMON_DWORD_ALIGN-1:0] != `RESMON_DWORD_LOW_ZERO); // see R12
   assign misaligned       = (op_size_in == `RESMON_SZ_DWORD) ? dword_misaligned : word_misaligned;
   // doubleword pairs refused in a 32-bit build
   assign size_ok = (op_size_in == `RESMON_SZ_WORD) || (IS_64BIT != `RESMON_BUILD_32); // see R11
   assign op_bad  = misaligned || !size_ok;

   // a reserve outranks a conditional store in the same cycle; both are ignored while a load is pending
   assign idle      = (state_r == ST_IDLE);
   assign rsv_take  = idle && rsv_ld_in;
   assign rsv_start = rsv_take && !op_bad;
   assign cs_take   = idle && !rsv_ld_in && cond_st_in;
   assign ld_return = (state_r == ST_LOAD) && mem_rd_valid_in;

   // any remote modify, and every remote cache op: clearing on those is the safe choice
   assign snoop_clears = snoop_modify_in || snoop_cache_op_in; // see R7 see R8 see R9
   assign snoop_hit    = snoop_valid_in && snoop_clears && (snoop_tag == rsv_tag_r);
   // judged on the reservation as it stood, so a remote hit in the same cycle fails the store
   assign st_ok    = rsv_valid_out && !snoop_hit && !op_bad; // see R2
   assign cs_write = cs_take && st_ok;

   // reservation and sequencing
   always @* begin
      state_nxt     = state_r;
      rsv_tag_nxt   = rsv_tag_r;
      rsv_valid_nxt = rsv_valid_out;
      align_err_nxt = 1'b0;
      // exception_in and own_rc_update_in are not decoded: the reservation outlives both, see R9 see R10
      if (snoop_hit) begin
         rsv_valid_nxt = 1'b0; // see R7
      end
      case (state_r)
         ST_IDLE: begin
            if (rsv_take) begin
               if (op_bad) begin
                  align_err_nxt = 1'b1;
               end else begin
                  // one tag register: a new reserve replaces the old, see R4 see R5
                  rsv_tag_nxt   = op_tag; // see R1
                  rsv_valid_nxt = 1'b1;
                  state_nxt     = ST_LOAD;
               end
            end else if (cs_take) begin
               // cleared whatever the address, see R6
               rsv_valid_nxt = 1'b0;
               align_err_nxt = op_bad;
            end
         end
         ST_LOAD: begin
            // nothing waits for a conditional store, see R14
            if (ld_return) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // requests toward memory
   always @* begin
      mem_rd_req_nxt  = rsv_start;
      mem_addr_nxt    = mem_addr_out;
      mem_wr_nxt      = cs_write; // see R11
      mem_wr_data_nxt = mem_wr_data_out;
      mem_wr_size_nxt = mem_wr_size_out;
      if (rsv_start) begin
         mem_addr_nxt = op_addr_in;
      end else if (cs_write) begin
         mem_addr_nxt    = op_addr_in;
         mem_wr_data_nxt = st_data_in;
         mem_wr_size_nxt = op_size_in;
      end
   end

   // results toward the core
   always @* begin
      ld_valid_nxt = ld_return;
      ld_data_nxt  = ld_data_out;
      st_done_nxt  = cs_take;
      cr_nxt       = first_condition_field_out;
      if (ld_return) begin
         ld_data_nxt = mem_rd_data_in; // see R1
      end
      if (cs_take) begin
         cr_nxt                 = `RESMON_CR_ZERO;
         cr_nxt[`RESMON_CR_BIT] = st_ok; // see R3
      end
   end

   always @(posedge clk_in) begin
      if (rst_in) begin
         state_r       <= ST_IDLE;
         rsv_tag_r     <= `RESMON_TAG_ZERO;
         rsv_valid_out <= 1'b0; // see R16
         align_err_out <= 1'b0;
      end else begin
         state_r       <= state_nxt;
         rsv_tag_r     <= rsv_tag_nxt;
         rsv_valid_out <= rsv_valid_nxt;
         align_err_out <= align_err_nxt;
      end
   end

   always @(posedge clk_in) begin
      if (rst_in) begin
         mem_rd_req_out  <= 1'b0;
         mem_addr_out    <= `RESMON_ADDR_ZERO;
         mem_wr_out      <= 1'b0;
         mem_wr_data_out <= `RESMON_DATA_ZERO;
         mem_wr_size_out <= `RESMON_SZ_WORD;
      end else begin
         mem_rd_req_out  <= mem_rd_req_nxt;
         mem_addr_out    <= mem_addr_nxt;
         mem_wr_out      <= mem_wr_nxt;
         mem_wr_data_out <= mem_wr_data_nxt;
         mem_wr_size_out <= mem_wr_size_nxt;
      end
   end

   always @(posedge clk_in) begin
      if (rst_in) begin
         ld_valid_out              <= 1'b0;
         ld_data_out               <= `RESMON_DATA_ZERO;
         st_done_out               <= 1'b0;
         first_condition_field_out <= `RESMON_CR_ZERO;
      end else begin
         ld_valid_out              <= ld_valid_nxt;
         ld_data_out               <= ld_data_nxt;
         st_done_out               <= st_done_nxt;
         first_condition_field_out <= cr_nxt;
      end
   end

endmodule
`default_nettype wire

// file: resmon_checker.sv
// port assertions for the reservation monitor
`timescale 1ns/100ps
`default_nettype none
module resmon_checker (
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic        rsv_ld_in,
   input wire logic        cond_st_in,
   input wire logic        snoop_valid_in,
   input wire logic        snoop_modify_in,
   input wire logic        snoop_cache_op_in,
   input wire logic        mem_rd_req_out,
   input wire logic        mem_wr_out,
   input wire logic        st_done_out,
   input wire logic        rsv_valid_out,
   input wire logic        align_err_out,
   input wire logic [63:0] snoop_addr_in,
   input wire logic [63:0] mem_addr_out,
   input wire logic [3:0]  first_condition_field_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   property p_rd; mem_rd_req_out |-> $past(rsv_ld_in) && rsv_valid_out; endproperty
   a_rd: assert property (p_rd) else $error("read");
   property p_cr; st_done_out |-> first_condition_field_out == {1'h0, mem_wr_out, 2'h0}; endproperty
   a_cr: assert property (p_cr) else $error("flag");
   property p_wr; mem_wr_out |-> st_done_out && $past(rsv_valid_out); endproperty
   a_wr: assert property (p_wr) else $error("write");
   property p_cl; st_done_out |-> !rsv_valid_out; endproperty
   a_cl: assert property (p_cl) else $error("kept");
   property p_sn; snoop_valid_in && (snoop_modify_in || snoop_cache_op_in) && !rsv_ld_in
      && snoop_addr_in[63:7] == mem_addr_out[63:7] |=> !rsv_valid_out; endproperty
   a_sn: assert property (p_sn) else $error("snoop");
   property p_kp; rsv_valid_out && !rsv_ld_in && !cond_st_in && !snoop_valid_in |=> rsv_valid_out; endproperty
   a_kp: assert property (p_kp) else $error("lost");
   property p_rs; disable iff (1'h0) rst_in |=> !rsv_valid_out && first_condition_field_out == 4'h0; endproperty
   a_rs: assert property (p_rs) else $error("reset");
   property p_hd; !st_done_out |-> $stable(first_condition_field_out); endproperty
   a_hd: assert property (p_hd) else $error("held");
   property p_al; align_err_out |-> !mem_rd_req_out && !mem_wr_out; endproperty
   a_al: assert property (p_al) else $error("align");
endmodule
bind resmon_monitor resmon_checker i_resmon_checker (.*);
`default_nettype wire

// file: resmon_mem_model.sv
// memory responder; latency follows address bits so both fast and slow replies occur
`timescale 1ns/100ps
`default_nettype none
module resmon_mem_model (
   input  wire logic        clk_in, req_in,
   input  wire logic [63:0] addr_in,
   output var  logic        valid_out = 1'h0,
   output var  logic [63:0] data_out = 64'h0
);
   always @(posedge clk_in) begin
      {valid_out, data_out} <= {1'h0, ~data_out}; // idle bus never shows stale data
      if (req_in) begin
         repeat (addr_in[4:3]) @(posedge clk_in);
         {valid_out, data_out} <= {1'h1, addr_in ^ 64'h5A5AC3C30F0F9696};
      end
   end
endmodule
`default_nettype wire

// file: resmon_monitor_test.sv
// random reserve, snoop and conditional store bench
`timescale 1ns/100ps
`default_nettype none
module resmon_monitor_test;
   logic        clk_in, rst_in, rsv_ld_in, cond_st_in, op_size_in, snoop_valid_in, snoop_modify_in;
   logic        snoop_cache_op_in, own_rc_update_in, exception_in, mem_rd_valid_in, mem_rd_req_out, mem_wr_out;
   logic        mem_wr_size_out, ld_valid_out, st_done_out, rsv_valid_out, align_err_out;
   logic [63:0] op_addr_in, st_data_in, snoop_addr_in, a, mem_rd_data_in, mem_addr_out, mem_wr_data_out, ld_data_out;
   logic [3:0]  first_condition_field_out;
   int          mismatches, checks_done, ev, i;
   resmon_monitor i_resmon_monitor (.clk_in, .rst_in, .rsv_ld_in, .cond_st_in, .op_size_in, .op_addr_in,
      .st_data_in, .mem_rd_valid_in, .mem_rd_data_in, .snoop_valid_in, .snoop_addr_in, .snoop_modify_in,
      .snoop_cache_op_in, .own_rc_update_in, .exception_in, .mem_rd_req_out, .mem_addr_out, .mem_wr_out,
      .mem_wr_data_out, .mem_wr_size_out, .ld_valid_out, .ld_data_out, .st_done_out, .first_condition_field_out,
      .rsv_valid_out, .align_err_out);
   resmon_mem_model i_resmon_mem_model (.clk_in, .req_in(mem_rd_req_out), .addr_in(mem_addr_out),
      .valid_out(mem_rd_valid_in), .data_out(mem_rd_data_in));
   initial begin
      clk_in = 1'h0;
      forever #5 clk_in = ~clk_in;
   end
   task chk(input logic [63:0] seen, exp);
      checks_done++;
      if (seen !== exp) $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      if (seen !== exp) mismatches++;
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // partner memory answers a read with the address folded by a fixed pattern
   function automatic logic [63:0] exp_ld(input logic [63:0] ad);
      return ad ^ 64'h5A5AC3C30F0F9696;
   endfunction
   function automatic logic [3:0] exp_cr(input logic ok);
      return {1'h0, ok, 2'h0};
   endfunction
   task op(input logic rl, input logic [63:0] ad, input logic ok);
      logic [63:0] sd;
      sd = {32'($urandom), 32'($urandom)};
      @(posedge clk_in);
      {rsv_ld_in, cond_st_in, op_addr_in, st_data_in} <= {rl, !rl, ad, sd};
      @(posedge clk_in);
      {rsv_ld_in, cond_st_in} <= 2'h0;
      #1;
      for (i = 0; i < 9 && (rl ? ld_valid_out : st_done_out) !== 1'h1; i++) @(posedge clk_in) #1;
      if (i == 9) begin
         mismatches++;
         stop_test;
      end
      chk(rl ? ld_data_out : first_condition_field_out, rl ? exp_ld(ad) : exp_cr(ok));
      chk(rsv_valid_out, rl);
      chk(align_err_out, 1'h0);
      if (rl || ok) chk(mem_addr_out, ad);
      if (!rl) chk(mem_wr_out, ok);
      if (!rl && ok) chk(mem_wr_data_out, sd);
      if (!rl && ok) chk(mem_wr_size_out, op_size_in);
   endtask
   initial begin
      {rsv_ld_in, cond_st_in, op_size_in, snoop_valid_in, snoop_modify_in, snoop_cache_op_in, own_rc_update_in,
         exception_in, op_addr_in, st_data_in, snoop_addr_in} = 200'h0;
      rst_in = 1'h1;
      ev = $urandom(84949);
      repeat (16) @(posedge clk_in);
      rst_in <= 1'h0;
      op(1'h0, 64'h0, 1'h0);
      // word slip, then doubleword slip on a word-aligned address: both refused
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_in);
         {rsv_ld_in, op_size_in, op_addr_in} <= {1'h1, 1'(k), (k == 0) ? 64'h41 : 64'h44};
         @(posedge clk_in);
         rsv_ld_in <= 1'h0;
         #1;
         chk(align_err_out, 1'h1);
         chk(mem_rd_req_out, 1'h0);
         chk(rsv_valid_out, 1'h0);
      end
      $display("test misaligned done");
      for (int t = 0; t < 40; t++) begin
         a = {32'($urandom), 29'($urandom), 3'h0};
         op_size_in <= 1'($urandom);
         op(1'h1, a, 1'h0);
         ev = $urandom_range(6);
         @(posedge clk_in);
         {exception_in, own_rc_update_in, snoop_valid_in, snoop_modify_in, snoop_cache_op_in} <=
            {ev == 1, ev == 2, ev > 2 && ev < 6, ev != 4, ev == 4};
         snoop_addr_in <= (ev == 5) ? a ^ 64'h80 : {a[63:7], 7'($urandom)};
         @(posedge clk_in);
         {exception_in, own_rc_update_in, snoop_valid_in} <= 3'h0;
         if (ev == 6) a = a ^ 64'h100;
         if (ev == 6) op(1'h1, a, 1'h0);
         op(1'h0, a, ev != 3 && ev != 4);
         $display("test %0d done", t);
      end
      op(1'h0, a, 1'h0);
      stop_test;
   end
endmodule
`default_nettype wire
